/* rtl/pst_top.sv */
// Profile selection and test mode control, top level
// Behaviour
// R1: Normal polarity: energized input gives profile B after the delay, else profile A.
// R2: Inverted polarity: energized input gives A; de-energized gives B after the delay.
// R3: Input switching only when both profiles assign the same select input.
// R4: At power-up with B requested by input, enter B without delay.
// R5: Selection is level based; B stays while the effective request is high.
// R6: Remote select-B on one-profile cell makes it two-profile with B active.
// R7: Panel or remote one-profile selection applies profile A and rewrites the cell.
// R8: Remote profile changes are refused while a select input is assigned.
// R9: No input assigned: follow panel/remote cell; assigned: input alone decides.
// R10: Rejected remote profile commands are dropped, never kept for later.
// R11: Active profile can be routed to an output contact and to leds.
// R12: With one profile configured, profile A is always used.
// R13: Test setting: disabled, enabled with outputs, enabled with outputs blocked.
// R14: Test mode entered from the panel returns to disabled after five minutes.
// R15: Test mode from input, command or panel; ends on input low or command.
// R16: Alarm led lit during test mode; test state routable to a led.
// R17: Blocked test mode keeps contacts off while leds still follow protection.
// R18: Test-mode control command reaches the device only from the Modbus master.
// R19: Switch-over timer restarts whenever the request falls back to A.
// R20: Profile and test indications are registered, one cycle after state change.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module pst_top
  import pst_pkg::*;
#(
  parameter int unsigned TEST_TIMEOUT = TEST_TIMEOUT_TICKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sel_pin,
  input wire logic test_pin,
  input wire logic [NUM_OUT-1:0] prot_out_req,
  input wire logic [NUM_LED-1:0] prot_led_req,
  input wire logic prot_trip,
  output logic [NUM_OUT-1:0] contact_out,
  output logic [NUM_LED-1:0] led_out,
  output logic trip_led,
  output logic alarm_led,
  output logic profile_b_active,
  output logic test_active
);
  logic [7:0] ctrl_reg;
  logic [15:0] delay_reg;
  logic [7:0] route_reg;
  logic [4:0] cmd_pulse;
  logic [31:0] stat_word;
  logic [1:0] sel_sync_reg;
  logic [1:0] test_sync_reg;
  logic test_pin_prev_reg;
  logic [16:0] div_reg;
  logic tick;
  logic [15:0] sw_cnt_reg;
  logic [18:0] test_cnt_reg;
  logic count_two_reg;
  logic cell_b_reg;
  logic input_b_reg;
  logic powerup_reg;
  logic active_b;
  logic assigned;
  logic eff_req;
  logic ctrl_wr;
  pst_test_t test_reg;
  logic test_from_panel_reg;
  logic test_en;
  logic [3:0] out_profile_sel;
  logic [3:0] led_test_sel;
  logic [NUM_OUT-1:0] contact_next;
  logic [NUM_LED-1:0] led_next;

  pst_apb_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .stat_in(stat_word),
    .ctrl_reg(ctrl_reg),
    .delay_reg(delay_reg),
    .route_reg(route_reg),
    .cmd_pulse(cmd_pulse)
  );

  // Pins cross into the clock domain through two flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_sync_reg <= 2'b00;
      test_sync_reg <= 2'b00;
      test_pin_prev_reg <= 1'b0;
    end else begin
      sel_sync_reg <= {sel_sync_reg[0], sel_pin};
      test_sync_reg <= {test_sync_reg[0], test_pin};
      test_pin_prev_reg <= test_sync_reg[1];
    end
  end

  // Millisecond tick enable for both timers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_reg <= 17'h00000;
    else if (div_reg == TICK_LAST) div_reg <= 17'h00000;
    else div_reg <= div_reg + 17'h00001;
  end
  assign tick = (div_reg == TICK_LAST);

  // Input counts only when both profiles assign it
  assign assigned = ctrl_reg[CTRL_ASGA] & ctrl_reg[CTRL_ASGB]; // [R3]
  // Effective request: polarity chosen by the inversion bit
  assign eff_req = sel_sync_reg[1] ^ ctrl_reg[CTRL_INV]; // [R1] [R2]

  // Switch-over timer; any drop back to A restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_cnt_reg <= 16'h0000;
      input_b_reg <= 1'b0;
      powerup_reg <= 1'b1;
    end else begin
      // Configuration is volatile, so the power-up choice waits for the first assignment
      if (assigned) powerup_reg <= 1'b0;
      if (!assigned || !eff_req) begin
        sw_cnt_reg <= 16'h0000; // [R19]
        input_b_reg <= 1'b0; // [R1] [R2]
      end else if (powerup_reg) begin
        input_b_reg <= 1'b1; // [R4]
      end else if (!input_b_reg) begin
        if (sw_cnt_reg >= delay_reg) input_b_reg <= 1'b1; // [R1] [R2]
        else if (tick) sw_cnt_reg <= sw_cnt_reg + 16'h0001;
      end
      // Holds B while request stays high [R5]
    end
  end

  // Panel write of the control byte, seen in its access cycle
  assign ctrl_wr = psel & penable & pwrite & pready & (paddr == OFS_CTRL) & pstrb[0];

  // Shared selection cell; last writer wins, so a remote change persists
  // A command pulse trails its own transfer, so it never meets a panel write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_two_reg <= 1'b0;
      cell_b_reg <= 1'b0;
    end else if (ctrl_wr) begin
      count_two_reg <= pwdata[CTRL_COUNT]; // [R7]
      cell_b_reg <= pwdata[CTRL_SEL];
    end else if (!assigned && cmd_pulse[CMD_REM_B]) begin
      // Remote commands only act now; nothing is queued [R8] [R10]
      count_two_reg <= 1'b1; // [R6]
      cell_b_reg <= 1'b1; // [R6]
    end else if (!assigned && cmd_pulse[CMD_REM_ONE]) begin
      count_two_reg <= 1'b0; // [R7]
      cell_b_reg <= 1'b0; // [R7]
    end
  end

  // Priority: input decides when assigned, else cell; one profile forces A
  assign active_b = count_two_reg & (assigned ? input_b_reg : cell_b_reg); // [R9] [R12]

  // Test mode state; panel entry starts the timeout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_reg <= PST_TEST_OFF;
      test_from_panel_reg <= 1'b0;
      test_cnt_reg <= 19'h00000;
    end else begin
      if (cmd_pulse[CMD_TEST_OFF] ||
          (test_pin_prev_reg && !test_sync_reg[1])) begin
        test_reg <= PST_TEST_OFF; // [R15]
        test_from_panel_reg <= 1'b0;
      end else if (cmd_pulse[CMD_TEST_ON]) begin
        // Remote command path, Modbus master only [R18]
        test_reg <= cmd_pulse[CMD_TEST_BLK] ? PST_TEST_BLOCK : PST_TEST_TRIPS; // [R13]
        test_from_panel_reg <= 1'b0;
      end else if (test_sync_reg[1] && !test_pin_prev_reg) begin
        test_reg <= ctrl_reg[CTRL_TMODE] ? PST_TEST_BLOCK : PST_TEST_TRIPS; // [R15]
        test_from_panel_reg <= 1'b0;
      end else if (ctrl_reg[CTRL_TMIN] && test_reg == PST_TEST_OFF && !test_from_panel_reg) begin
        test_reg <= ctrl_reg[CTRL_TMODE] ? PST_TEST_BLOCK : PST_TEST_TRIPS; // [R13]
        test_from_panel_reg <= 1'b1;
        test_cnt_reg <= 19'h00000;
      end else if (test_from_panel_reg && !ctrl_reg[CTRL_TMIN]) begin
        test_reg <= PST_TEST_OFF;
        test_from_panel_reg <= 1'b0;
      end else if (test_from_panel_reg && test_reg != PST_TEST_OFF && tick) begin
        if (test_cnt_reg >= 19'(TEST_TIMEOUT - 1)) test_reg <= PST_TEST_OFF; // [R14]
        else test_cnt_reg <= test_cnt_reg + 19'h00001;
      end
    end
  end
  assign test_en = (test_reg != PST_TEST_OFF);

  // Route fields: low nibble picks contacts and leds for profile B, high nibble leds for test
  assign out_profile_sel = route_reg[3:0];
  assign led_test_sel = route_reg[7:4];

  // Per-output gating and indication routing
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
      assign contact_next[gi] = (test_reg != PST_TEST_BLOCK) &
        (prot_out_req[gi] | (out_profile_sel[gi] & active_b)); // [R17] [R11]
      assign led_next[gi] = prot_led_req[gi] | (out_profile_sel[gi] & active_b) |
        (led_test_sel[gi] & test_en); // [R11] [R16]
    end
  endgenerate

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      contact_out <= '0;
      led_out <= '0;
      trip_led <= 1'b0;
      alarm_led <= 1'b0;
      profile_b_active <= 1'b0;
      test_active <= 1'b0;
    end else begin
      contact_out <= contact_next; // [R17]
      led_out <= led_next;
      trip_led <= prot_trip; // [R17]
      alarm_led <= test_en; // [R16]
      profile_b_active <= active_b; // [R20]
      test_active <= test_en; // [R20]
    end
  end

  // Status word
  assign stat_word = {24'h000000, 1'b0, test_from_panel_reg, test_reg, assigned,
                      input_b_reg, count_two_reg, active_b};
endmodule
`default_nettype wire

/* rtl/pst_pkg.sv */
// Package: constants and types for profile select and test mode
package pst_pkg;
  // Clock rate and derived cycle counts
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Divider producing a 1 ms tick enable
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);
  // Test mode timeout from the panel, in minutes and in ms ticks
  localparam int unsigned TEST_TIMEOUT_MIN = 5;
  localparam int unsigned TEST_TIMEOUT_TICKS = TEST_TIMEOUT_MIN * 60 * 1000;
  // Default switch-over delay in ms ticks
  localparam logic [15:0] SW_DELAY_RST = 16'h0064;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_DELAY = 12'h004;
  localparam logic [11:0] OFS_CMD = 12'h008;
  localparam logic [11:0] OFS_STAT = 12'h00c;
  localparam logic [11:0] OFS_ROUTE = 12'h010;

  // Control register fields
  localparam int unsigned CTRL_COUNT = 0;
  localparam int unsigned CTRL_SEL = 1;
  localparam int unsigned CTRL_INV = 2;
  localparam int unsigned CTRL_ASGA = 3;
  localparam int unsigned CTRL_ASGB = 4;
  localparam int unsigned CTRL_TMIN = 5;
  localparam int unsigned CTRL_TMODE = 6;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Command register fields (write one to act)
  localparam int unsigned CMD_REM_B = 0;
  localparam int unsigned CMD_REM_ONE = 1;
  localparam int unsigned CMD_TEST_ON = 2;
  localparam int unsigned CMD_TEST_OFF = 3;
  localparam int unsigned CMD_TEST_BLK = 4;

  // Route register: which outputs and leds carry indications
  localparam int unsigned NUM_OUT = 4;
  localparam int unsigned NUM_LED = 4;

  // Test mode setting encodings
  typedef enum logic [1:0] {
    PST_TEST_OFF = 2'b00,
    PST_TEST_TRIPS = 2'b01,
    PST_TEST_BLOCK = 2'b10
  } pst_test_t;
endpackage

/* rtl/pst_apb_regs.sv */
// APB slave holding the configuration and command registers
`timescale 1ns/10ps
`default_nettype none
module pst_apb_regs
  import pst_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] stat_in,
  output logic [7:0] ctrl_reg,
  output logic [15:0] delay_reg,
  output logic [7:0] route_reg,
  output logic [4:0] cmd_pulse
);
  logic wr_en;
  logic mapped;

  // Zero wait state: answer in the access cycle
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign mapped = (paddr == OFS_CTRL) | (paddr == OFS_DELAY) | (paddr == OFS_CMD) |
                  (paddr == OFS_STAT) | (paddr == OFS_ROUTE);
  assign pslverr = psel & penable & ~mapped;

  // Register writes honour byte strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST;
      delay_reg <= SW_DELAY_RST;
      route_reg <= 8'h00;
    end else if (wr_en) begin
      if (paddr == OFS_CTRL && pstrb[0]) ctrl_reg <= pwdata[7:0];
      if (paddr == OFS_ROUTE && pstrb[0]) route_reg <= pwdata[7:0];
      if (paddr == OFS_DELAY) begin
        if (pstrb[0]) delay_reg[7:0] <= pwdata[7:0];
        if (pstrb[1]) delay_reg[15:8] <= pwdata[15:8];
      end
    end
  end

  // Commands are one-cycle pulses, never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cmd_pulse <= 5'h00;
    else if (wr_en && paddr == OFS_CMD && pstrb[0]) cmd_pulse <= pwdata[4:0];
    else cmd_pulse <= 5'h00;
  end

  // Read mux; unmapped reads return zero
  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL: prdata = {24'h000000, ctrl_reg};
      OFS_DELAY: prdata = {16'h0000, delay_reg};
      OFS_STAT: prdata = stat_in;
      OFS_ROUTE: prdata = {24'h000000, route_reg};
      default: prdata = 32'h0000_0000;
    endcase
  end
endmodule
`default_nettype wire

/* test/pst_top_props.sv */
// Checker bound to the profile and test mode top
`timescale 1ns/10ps
`default_nettype none
module pst_top_props
  import pst_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic prot_trip,
  input wire logic [NUM_OUT-1:0] contact_out,
  input wire logic trip_led,
  input wire logic alarm_led,
  input wire logic profile_b_active,
  input wire logic test_active
);
  logic wr, tcmd, cell_win;
  logic [7:0] sh_reg;
  logic blk_reg;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed writes, and command-register writes among them
  assign wr = psel && penable && pwrite && pready;
  assign tcmd = wr && paddr == OFS_CMD;
  // Control byte as software last wrote it, cell bits as remote last set them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_reg <= 8'h00;
    end else if (wr && paddr == OFS_CTRL) begin
      sh_reg <= pwdata[7:0];
    end else if (tcmd && !(sh_reg[CTRL_ASGA] && sh_reg[CTRL_ASGB])) begin
      if (pwdata[CMD_REM_B]) begin
        sh_reg[CTRL_COUNT] <= 1'b1;
        sh_reg[CTRL_SEL] <= 1'b1;
      end else if (pwdata[CMD_REM_ONE]) begin
        sh_reg[CTRL_COUNT] <= 1'b0;
        sh_reg[CTRL_SEL] <= 1'b0;
      end
    end
  end
  // Two profiles and no input assignment: the cell decides
  assign cell_win = sh_reg[CTRL_COUNT] && !(sh_reg[CTRL_ASGA] && sh_reg[CTRL_ASGB]);
  // Blocked kind of the last command-entered test
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_reg <= 1'b0;
    end else if (tcmd && (pwdata[CMD_TEST_ON] || pwdata[CMD_TEST_OFF])) begin
      blk_reg <= pwdata[CMD_TEST_ON] && pwdata[CMD_TEST_BLK];
    end
  end
  chk_apb_ready: assert property (psel && penable |-> pready)
    else $error("access without ready");
  chk_one_profile: assert property ((!sh_reg[CTRL_COUNT])[*3] |-> !profile_b_active)
    else $error("profile b with one profile");
  // Stable window keeps a fresh write out of the comparison
  chk_cell_follow: assert property ((cell_win && $stable(sh_reg))[*4] |->
    profile_b_active == sh_reg[CTRL_SEL])
    else $error("profile not following cell");
  chk_block_out: assert property ((blk_reg && test_active)[*2] |-> contact_out == '0)
    else $error("contact on in blocked test");
  chk_test_on: assert property (tcmd && pwdata[CMD_TEST_ON] |-> ##[1:4] test_active)
    else $error("test command not entered");
  chk_test_off: assert property (tcmd && pwdata[CMD_TEST_OFF] |-> ##[1:4] !test_active)
    else $error("test not left on command");
  chk_alarm_test: assert property (alarm_led == test_active)
    else $error("alarm led differs from test");
  chk_trip_follow: assert property ($past(presetn) |-> trip_led == $past(prot_trip))
    else $error("trip led not following trip");
  cover property ($rose(profile_b_active));
  cover property ($rose(test_active));
  cover property (blk_reg && test_active);
endmodule
bind pst_top pst_top_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prot_trip(prot_trip), .contact_out(contact_out), .trip_led(trip_led),
  .alarm_led(alarm_led), .profile_b_active(profile_b_active), .test_active(test_active));
`default_nettype wire

/* test/pst_field.sv */
// Field side model: binary inputs and protection requests
`timescale 1ns/10ps
`default_nettype none
module pst_field (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic set_sel,
  input wire logic set_test,
  input wire logic set_trip,
  input wire logic [3:0] set_req,
  output logic sel_pin,
  output logic test_pin,
  output logic prot_trip,
  output logic [3:0] prot_out_req,
  output logic [3:0] prot_led_req
);
  // Pins carry levels only; test commands come over the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {sel_pin, test_pin, prot_trip, prot_out_req, prot_led_req} <= 11'h000;
    end else begin
      {sel_pin, test_pin, prot_trip, prot_out_req, prot_led_req} <=
        {set_sel, set_test, set_trip, set_req, set_req};
    end
  end
endmodule
`default_nettype wire

/* test/pst_top_tb.sv */
// Self-checking bench for profile selection and test mode
`timescale 1ns/10ps
`default_nettype none
module pst_top_tb
  import pst_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, sel_pin, test_pin, prot_trip, trip_led, alarm_led;
  logic profile_b_active, test_active;
  logic [3:0] prot_out_req, prot_led_req, contact_out, led_out;
  logic set_sel = 1'b0, set_test = 1'b0, set_trip = 1'b0;
  logic [3:0] set_req = 4'h0;
  int mismatches = 0;
  int checks_done = 0;
  // Free running 100 MHz clock
  always #5 pclk = ~pclk;
  pst_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sel_pin(sel_pin), .test_pin(test_pin),
    .prot_out_req(prot_out_req), .prot_led_req(prot_led_req), .prot_trip(prot_trip),
    .contact_out(contact_out), .led_out(led_out), .trip_led(trip_led),
    .alarm_led(alarm_led), .profile_b_active(profile_b_active), .test_active(test_active));
  pst_field u_field (.pclk(pclk), .presetn(presetn), .set_sel(set_sel),
    .set_test(set_test), .set_trip(set_trip), .set_req(set_req), .sel_pin(sel_pin),
    .test_pin(test_pin), .prot_trip(prot_trip), .prot_out_req(prot_out_req),
    .prot_led_req(prot_led_req));
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic pins(input logic s, input logic t, input logic [3:0] q);
    @(posedge pclk);
    {set_sel, set_test, set_trip, set_req} <= {s, t, q[0], q};
    @(negedge pclk);
  endtask
  // Fixed settle time, so a brief wrong value cannot pass early
  // Compares profile (t=0) or test flag (t=1)
  task automatic chk(input bit t, input logic exp);
    logic v;
    repeat (12) @(negedge pclk);
    v = t ? test_active : profile_b_active;
    cmp({31'h0, v}, {31'h0, exp});
  endtask
  // Watchdog: the sequence needs well under 5000 cycles
  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    cmp(rd, {24'h0, CTRL_RST});
    apb(1'b0, OFS_DELAY, 32'h0);
    cmp(rd, {16'h0, SW_DELAY_RST});
    apb(1'b0, 12'h0ff, 32'h0);
    cmp({er, rd[30:0]}, 32'h80000000);
    apb(1'b1, OFS_DELAY, 32'h0);
    pins(1'b1, 1'b0, 4'h0);
    apb(1'b1, OFS_CTRL, 32'h18);
    chk(0, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h19);
    chk(0, 1'b1);
    pins(1'b0, 1'b0, 4'h0);
    chk(0, 1'b0);
    apb(1'b1, OFS_CMD, 32'h1);
    chk(0, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h01);
    chk(0, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h00);
    apb(1'b1, OFS_CMD, 32'h01);
    chk(0, 1'b1);
    apb(1'b0, OFS_STAT, 32'h0);
    cmp({30'h0, rd[1:0]}, 32'h3);
    apb(1'b1, OFS_CMD, 32'h02);
    chk(0, 1'b0);
    apb(1'b0, OFS_STAT, 32'h0);
    cmp({30'h0, rd[1:0]}, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h1d);
    chk(0, 1'b1);
    pins(1'b1, 1'b0, 4'h0);
    chk(0, 1'b0);
    pins(1'b0, 1'b0, 4'h0);
    apb(1'b1, OFS_CTRL, 32'h0b);
    chk(0, 1'b1);
    apb(1'b1, OFS_ROUTE, 32'h01);
    apb(1'b1, OFS_CTRL, 32'h03);
    chk(0, 1'b1);
    cmp({28'h0, contact_out}, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h01);
    pins(1'b0, 1'b0, 4'hf);
    apb(1'b1, OFS_CMD, 32'h04);
    chk(1, 1'b1);
    cmp({27'h0, alarm_led, contact_out}, 32'h1f);
    apb(1'b1, OFS_CMD, 32'h08);
    chk(1, 1'b0);
    apb(1'b1, OFS_CMD, 32'h14);
    chk(1, 1'b1);
    cmp({23'h0, trip_led, led_out, contact_out}, 32'h1f0);
    apb(1'b1, OFS_CMD, 32'h08);
    chk(1, 1'b0);
    pins(1'b0, 1'b1, 4'h0);
    chk(1, 1'b1);
    pins(1'b0, 1'b0, 4'h0);
    chk(1, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h21);
    chk(1, 1'b1);
    apb(1'b1, OFS_CTRL, 32'h01);
    chk(1, 1'b0);
    // Second reset: pin already requests B when the input is first assigned
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    pins(1'b1, 1'b0, 4'h0);
    chk(0, 1'b0);
    apb(1'b0, OFS_DELAY, 32'h0);
    cmp(rd, {16'h0, SW_DELAY_RST});
    apb(1'b1, OFS_CTRL, 32'h19);
    chk(0, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire
